// >>> hw/afc_consts.vh
// Constants for the automatic fan control and tach measurement block.
// Notes on behaviour
// RULE1: Test register bit 1 inverts the pulse-width output polarity.
// RULE2: Automatic control runs only while configuration bit 0 is set.
// RULE3: Configuration bits 5 and 6 hand DAC and pulse outputs to automatic control.
// RULE4: Three signed start temperatures, local and two remote, at 10h to 12h.
// RULE5: Software writes 127 degrees to exclude a channel from automatic control.
// RULE6: Upper nibbles of 04h and 05h give the automatic minimum drive levels.
// RULE7: With both outputs automatic, the DAC nibble sets both minimums.
// RULE8: Minimum DAC code is sixteen times nibble; duty is 6.67 percent per step.
// RULE9: First start runs the fan at full drive for two seconds.
// RULE10: Drive ramps linearly over 20 degrees, toward 100 percent or code 240.
// RULE11: Above start plus 20 degrees the DAC steps to full scale.
// RULE12: Each channel's demand is computed alone; the highest one wins.
// RULE13: Fan stops only when all sensors are 4 degrees below their start.
// RULE14: Each automatic start or stop raises one interrupt event.
// RULE15: Register 01h bits choose tach or logic per pin; resets to zero.
// RULE16: Speed is a period count of 22.5 kHz ticks over two tach periods.
// RULE17: Software sets monitor bit, and interrupt enable bit 1 for the output.
// RULE18: A count reaching FFh marks a dead fan and ends that measurement.
// RULE19: Counter restarts at second rising edge and stops at the fourth.
// RULE20: No measurement for 1.8 s after monitor start; results read zero.
// RULE21: Per-channel prescaler 1, 2, 4 or 8 in 02h and 03h, default 2.
// RULE22: Count equals oscillator rate times 60 over speed times divisor.
// RULE23: Channels are measured in order 0 to 7, then repeat.
// RULE24: Logic pins and stalled fans time out after 255 ticks.
// RULE25: A count above the low-speed limit raises a fan failure event.
// RULE26: Tach inputs are synchronised and rising edges detected.
// RULE27: Each channel's final count is stored in its read-only result register.
`ifndef AFC_CONSTS_VH
`define AFC_CONSTS_VH
// Register indices; byte address is four times the index.
`define AFC_IDX_CFG        5'h00
`define AFC_IDX_PINSEL     5'h01
`define AFC_IDX_PRE_LO     5'h02
`define AFC_IDX_PRE_HI     5'h03
`define AFC_IDX_DAC        5'h04
`define AFC_IDX_PWM        5'h05
`define AFC_IDX_EVENT      5'h06
`define AFC_IDX_TMIN_L     5'h10
`define AFC_IDX_TMIN_A     5'h11
`define AFC_IDX_TMIN_B     5'h12
`define AFC_IDX_TEST       5'h14
`define AFC_IDX_RESULT     2'h1
`define AFC_IDX_LIMIT      2'h3
// Field positions.
`define AFC_CFG_MON        0
`define AFC_CFG_INTEN      1
`define AFC_CFG_AUTO_DAC   5
`define AFC_CFG_AUTO_PWM   6
`define AFC_TEST_PWM_INV   1
`define AFC_EVT_AUTO       0
`define AFC_EVT_FAIL       1
// Reset values.
`define AFC_RST_CFG        8'h00
`define AFC_RST_PINSEL     8'h00
`define AFC_RST_PRE        8'h55
`define AFC_RST_DAC        8'hff
`define AFC_RST_PWM        8'hff
`define AFC_RST_TMIN       8'h7f
`define AFC_RST_TEST       8'h00
`define AFC_RST_LIMIT      8'hff
// Control law figures.
`define AFC_RAMP_DEG       20
`define AFC_HYST_DEG       4
`define AFC_DAC_TOP        8'hf0
`define AFC_FULL           8'hff
`define AFC_DAC_STEP       8'h10
`define AFC_DUTY_STEP      8'h11
`define AFC_TACH_MAX       8'hff
// Timing.
`define AFC_CLK_HZ         25000000
`define AFC_OSC_HZ         22500
`define AFC_PWM_HZ         75
`define AFC_SPINUP_MS      2000
`define AFC_MEAS_DELAY_MS  1800
`define AFC_OSC_DIV        (`AFC_CLK_HZ / `AFC_OSC_HZ)
`define AFC_PWM_DIV        (`AFC_CLK_HZ / (`AFC_PWM_HZ * 255))
`define AFC_SPINUP_CYC     (`AFC_SPINUP_MS * (`AFC_CLK_HZ / 1000))
`define AFC_DELAY_CYC      (`AFC_MEAS_DELAY_MS * (`AFC_CLK_HZ / 1000))
`endif

// >>> hw/afc_fan_control.v
// Automatic fan control, pulse and DAC drive, and eight-channel tach period measurement.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "afc_consts.vh"
module afc_fan_control #(
  parameter SPINUP_CYC = `AFC_SPINUP_CYC,
  parameter DELAY_CYC  = `AFC_DELAY_CYC
) (
  // Clock and reset.
  input  wire        clk,
  input  wire        reset,
  // Avalon-MM slave.
  input  wire [6:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Temperature results, two's complement degrees.
  input  wire [7:0]  temp_local,
  input  wire [7:0]  temp_remote_a,
  input  wire [7:0]  temp_remote_b,
  // Fan side.
  input  wire [7:0]  tach_or_logic_pin,
  output reg  [7:0]  dac_code,
  output reg         pwm_out,
  output reg         int_n
);

  // Register file.
  reg [7:0] cfg;
  reg [7:0] pin_sel;
  reg [7:0] pre_lo;
  reg [7:0] pre_hi;
  reg [7:0] dac_reg;
  reg [7:0] pwm_reg;
  reg [7:0] tmin_l;
  reg [7:0] tmin_a;
  reg [7:0] tmin_b;
  reg [7:0] test_reg;
  reg [7:0] limit [0:7];
  reg [7:0] result [0:7];
  reg       evt_auto;
  reg [7:0] evt_fail;
  reg       ack;

  // Demand of one channel: zero below start, ramp over 20 degrees, full above.
  function [7:0] demand;
    input [7:0] t;
    input [7:0] tmin;
    input [7:0] floor;
    input [7:0] top;
    input [7:0] full;
    reg signed [9:0] d;
    reg [31:0] span;
    begin
      d = $signed({{2{t[7]}}, t}) - $signed({{2{tmin[7]}}, tmin});
      span = 32'h00000000;
      if (d <= 0) begin
        demand = 8'h00;
      end else if (d > `AFC_RAMP_DEG) begin
        demand = full;
      end else begin
        span = ({24'h000000, top} - {24'h000000, floor}) * {22'h000000, d} / `AFC_RAMP_DEG;
        demand = floor + span[7:0];
      end
    end
  endfunction

  // True when the temperature is at or below start minus the hysteresis.
  function cooled;
    input [7:0] t;
    input [7:0] tmin;
    begin
      cooled = $signed({{2{t[7]}}, t}) <=
               $signed({{2{tmin[7]}}, tmin}) - `AFC_HYST_DEG;
    end
  endfunction

  function [7:0] max3;
    input [7:0] a;
    input [7:0] b;
    input [7:0] c;
    reg [7:0] m;
    begin
      m = (a > b) ? a : b;
      max3 = (m > c) ? m : c;
    end
  endfunction

  // Bus decode; every access takes one wait cycle.
  wire [4:0] idx = avs_address[6:2];
  wire       hit_wr = avs_write & ack;
  wire       wr_lane = avs_byteenable[0];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;

  always @(posedge clk) begin
    if (reset) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  // Register writes.
  integer i;
  always @(posedge clk) begin
    if (reset) begin
      cfg <= `AFC_RST_CFG;
      // RULE15 reset to tach
      pin_sel <= `AFC_RST_PINSEL;
      // RULE21 default divisor two
      pre_lo <= `AFC_RST_PRE;
      pre_hi <= `AFC_RST_PRE;
      dac_reg <= `AFC_RST_DAC;
      pwm_reg <= `AFC_RST_PWM;
      tmin_l <= `AFC_RST_TMIN;
      tmin_a <= `AFC_RST_TMIN;
      tmin_b <= `AFC_RST_TMIN;
      test_reg <= `AFC_RST_TEST;
      for (i = 0; i < 8; i = i + 1) begin
        limit[i] <= `AFC_RST_LIMIT;
      end
    end else if (hit_wr && wr_lane) begin
      case (idx)
        `AFC_IDX_CFG:    cfg <= avs_writedata[7:0];
        `AFC_IDX_PINSEL: pin_sel <= avs_writedata[7:0];
        `AFC_IDX_PRE_LO: pre_lo <= avs_writedata[7:0];
        `AFC_IDX_PRE_HI: pre_hi <= avs_writedata[7:0];
        `AFC_IDX_DAC:    dac_reg <= avs_writedata[7:0];
        `AFC_IDX_PWM:    pwm_reg <= avs_writedata[7:0];
        // RULE4 three start thresholds
        `AFC_IDX_TMIN_L: tmin_l <= avs_writedata[7:0];
        `AFC_IDX_TMIN_A: tmin_a <= avs_writedata[7:0];
        `AFC_IDX_TMIN_B: tmin_b <= avs_writedata[7:0];
        `AFC_IDX_TEST:   test_reg <= avs_writedata[7:0];
        default: begin
          if (idx[4:3] == `AFC_IDX_LIMIT) begin
            limit[idx[2:0]] <= avs_writedata[7:0];
          end
        end
      endcase
    end
  end

  // Read data mux; unmapped words read zero.
  reg [7:0] rd;
  always @* begin
    case (idx)
      `AFC_IDX_CFG:    rd = cfg;
      `AFC_IDX_PINSEL: rd = pin_sel;
      `AFC_IDX_PRE_LO: rd = pre_lo;
      `AFC_IDX_PRE_HI: rd = pre_hi;
      `AFC_IDX_DAC:    rd = dac_reg;
      `AFC_IDX_PWM:    rd = pwm_reg;
      `AFC_IDX_EVENT:  rd = {6'h00, |evt_fail, evt_auto};
      `AFC_IDX_TMIN_L: rd = tmin_l;
      `AFC_IDX_TMIN_A: rd = tmin_a;
      `AFC_IDX_TMIN_B: rd = tmin_b;
      `AFC_IDX_TEST:   rd = test_reg;
      default: begin
        if (idx[4:3] == `AFC_IDX_RESULT) begin
          rd = result[idx[2:0]];
        end else if (idx[4:3] == `AFC_IDX_LIMIT) begin
          rd = limit[idx[2:0]];
        end else begin
          rd = 8'h00;
        end
      end
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack) begin
      avs_readdata <= {24'h000000, rd};
    end
  end

  // Automatic control law.
  // RULE2 monitor enable gate
  wire       mon = cfg[`AFC_CFG_MON];
  // RULE3 per-output selection
  wire       auto_dac = mon & cfg[`AFC_CFG_AUTO_DAC];
  wire       auto_pwm = mon & cfg[`AFC_CFG_AUTO_PWM];
  // RULE7 DAC nibble rules both
  wire [3:0] pwm_nib = cfg[`AFC_CFG_AUTO_DAC] ? dac_reg[7:4] : pwm_reg[7:4];
  // RULE6 RULE8 minimum levels
  wire [7:0] dac_min = {dac_reg[7:4], 4'h0};
  wire [7:0] duty_floor = pwm_nib * `AFC_DUTY_STEP;
  // RULE10 RULE11 RULE12 ramp and highest demand
  wire [7:0] dac_dem = max3(
    demand(temp_local, tmin_l, dac_min, `AFC_DAC_TOP, `AFC_FULL),
    demand(temp_remote_a, tmin_a, dac_min, `AFC_DAC_TOP, `AFC_FULL),
    demand(temp_remote_b, tmin_b, dac_min, `AFC_DAC_TOP, `AFC_FULL));
  wire [7:0] pwm_dem = max3(
    demand(temp_local, tmin_l, duty_floor, `AFC_FULL, `AFC_FULL),
    demand(temp_remote_a, tmin_a, duty_floor, `AFC_FULL, `AFC_FULL),
    demand(temp_remote_b, tmin_b, duty_floor, `AFC_FULL, `AFC_FULL));
  wire       any_hot = (dac_dem != 8'h00) | (pwm_dem != 8'h00);
  // RULE13 all three cooled
  wire       all_cool = cooled(temp_local, tmin_l) & cooled(temp_remote_a, tmin_a) &
                        cooled(temp_remote_b, tmin_b);
  wire       auto_any = auto_dac | auto_pwm;

  reg        fan_on;
  reg [25:0] spin_cnt;
  wire       spinning = spin_cnt != 26'h0000000;
  wire       next_on = auto_any & (fan_on ? ~all_cool : any_hot);

  always @(posedge clk) begin
    if (reset) begin
      fan_on <= 1'b0;
      spin_cnt <= 26'h0000000;
    end else begin
      fan_on <= next_on;
      // RULE9 two second spin-up
      if (next_on & ~fan_on) begin
        spin_cnt <= SPINUP_CYC[25:0];
      end else if (spinning & next_on) begin
        spin_cnt <= spin_cnt - 26'h0000001;
      end else if (~next_on) begin
        spin_cnt <= 26'h0000000;
      end
    end
  end

  // Output selection: manual register value or automatic drive.
  always @(posedge clk) begin
    if (reset) begin
      dac_code <= `AFC_RST_DAC;
    end else if (!auto_dac) begin
      dac_code <= dac_reg;
    end else if (!fan_on) begin
      dac_code <= 8'h00;
    end else if (spinning) begin
      dac_code <= `AFC_FULL;
    end else begin
      dac_code <= (dac_dem > dac_min) ? dac_dem : dac_min;
    end
  end

  wire [7:0] duty = !auto_pwm ? pwm_reg :
                    !fan_on ? 8'h00 :
                    spinning ? `AFC_FULL :
                    (pwm_dem > duty_floor) ? pwm_dem : duty_floor;

  // Pulse generator: 255 steps per period, so duty FFh is always high unless test bit 1 inverts it.
  reg [10:0] pwm_pre;
  reg [7:0]  pwm_step;
  always @(posedge clk) begin
    if (reset) begin
      pwm_pre <= 11'h000;
      pwm_step <= 8'h00;
      pwm_out <= 1'b0;
    end else begin
      if (pwm_pre == `AFC_PWM_DIV - 1) begin
        pwm_pre <= 11'h000;
        pwm_step <= (pwm_step == 8'hfe) ? 8'h00 : pwm_step + 8'h01;
      end else begin
        pwm_pre <= pwm_pre + 11'h001;
      end
      // RULE1 polarity invert
      pwm_out <= (pwm_step < duty) ^ test_reg[`AFC_TEST_PWM_INV];
    end
  end

  // Tach input synchroniser and rising edge detect; reset to the pull-up level so no false edge.
  reg [7:0] tach_s1;
  reg [7:0] tach_s2;
  reg [7:0] tach_s3;
  always @(posedge clk) begin
    if (reset) begin
      tach_s1 <= 8'hff;
      tach_s2 <= 8'hff;
      tach_s3 <= 8'hff;
    end else begin
      // RULE26 two-stage sync
      tach_s1 <= tach_or_logic_pin;
      tach_s2 <= tach_s1;
      tach_s3 <= tach_s2;
    end
  end

  // Oscillator tick and measurement sequencer.
  reg [10:0] osc_pre;
  reg [25:0] delay_cnt;
  reg        mon_q;
  reg [2:0]  ch;
  reg [2:0]  edges;
  reg [7:0]  cnt;
  reg [2:0]  div_cnt;
  integer    n;
  wire       osc_tick = osc_pre == `AFC_OSC_DIV - 1;
  wire [1:0] dsel = ch[2] ? pre_hi[{ch[1:0], 1'b0} +: 2] : pre_lo[{ch[1:0], 1'b0} +: 2];
  wire [2:0] dmax = (3'h1 << dsel) - 3'h1;
  // RULE26 RULE24 logic pins ignore edges
  wire       rise = tach_s2[ch] & ~tach_s3[ch] & ~pin_sel[ch];
  wire       cnt_tick = osc_tick & (div_cnt == dmax);
  // RULE18 saturated count ends
  wire       timeout = cnt == `AFC_TACH_MAX;
  wire       done = (rise & (edges == 3'h3)) | timeout;
  wire       measuring = mon & (delay_cnt == 26'h0000000);
  wire       auto_evt = next_on ^ fan_on;
  wire       fail_clr = hit_wr & wr_lane & (idx == `AFC_IDX_EVENT) &
                        avs_writedata[`AFC_EVT_FAIL];

  always @(posedge clk) begin
    if (reset) begin
      osc_pre <= 11'h000;
      delay_cnt <= 26'h0000000;
      mon_q <= 1'b0;
      ch <= 3'h0;
      edges <= 3'h0;
      cnt <= 8'h00;
      div_cnt <= 3'h0;
      evt_fail <= 8'h00;
      for (n = 0; n < 8; n = n + 1) begin
        result[n] <= 8'h00;
      end
    end else begin
      mon_q <= mon;
      osc_pre <= osc_tick ? 11'h000 : osc_pre + 11'h001;
      if (fail_clr) begin
        evt_fail <= 8'h00;
      end
      if (mon & ~mon_q) begin
        // RULE20 hold off and zero results
        delay_cnt <= DELAY_CYC[25:0];
        for (n = 0; n < 8; n = n + 1) begin
          result[n] <= 8'h00;
        end
      end else if (delay_cnt != 26'h0000000) begin
        delay_cnt <= delay_cnt - 26'h0000001;
      end
      if (!measuring) begin
        ch <= 3'h0;
        edges <= 3'h0;
        cnt <= 8'h00;
        div_cnt <= 3'h0;
      end else if (done) begin
        // RULE27 store final count
        result[ch] <= cnt;
        // RULE25 count above limit fails
        if (cnt > limit[ch]) begin
          evt_fail[ch] <= 1'b1;
        end
        // RULE23 fixed channel order
        ch <= ch + 3'h1;
        edges <= 3'h0;
        cnt <= 8'h00;
        div_cnt <= 3'h0;
      end else begin
        if (rise) begin
          edges <= edges + 3'h1;
        end
        // RULE21 prescaler ahead of counter
        if (osc_tick) begin
          div_cnt <= (div_cnt == dmax) ? 3'h0 : div_cnt + 3'h1;
        end
        // RULE19 RULE16 RULE22 period count
        if (rise & (edges == 3'h1)) begin
          cnt <= 8'h00;
        end else if (cnt_tick) begin
          cnt <= cnt + 8'h01;
        end
      end
    end
  end

  // Automatic start/stop event and interrupt output.
  always @(posedge clk) begin
    if (reset) begin
      evt_auto <= 1'b0;
      int_n <= 1'b1;
    end else begin
      // RULE14 one event per start or stop
      if (auto_evt) begin
        evt_auto <= 1'b1;
      end else if (hit_wr & wr_lane & (idx == `AFC_IDX_EVENT) &
                   avs_writedata[`AFC_EVT_AUTO]) begin
        evt_auto <= 1'b0;
      end
      int_n <= ~(cfg[`AFC_CFG_INTEN] & (evt_auto | (|evt_fail)));
    end
  end

endmodule // afc_fan_control
`default_nettype wire

// >>> testbench/afc_fan_model.sv
// Behavioural fans: eight running fans whose tach lines are square waves.
`timescale 1ns/100ps
`default_nettype none
module afc_fan_model #(
  parameter FAST_HALF = 1111,
  parameter SLOW_HALF = 4444
) (
  // Clock.
  input  wire       clk,
  // Tach outputs.
  output reg  [7:0] tach
);
  integer cnt [0:7];
  integer i;
  // All fans start high, as the pull-up leaves them.
  initial begin
    tach = 8'hff;
    for (i = 0; i < 8; i = i + 1) begin
      cnt[i] = 0;
    end
  end
  // Fan 0 is fast; the others run at a quarter of its speed.
  always @(posedge clk) begin
    for (i = 0; i < 8; i = i + 1) begin
      cnt[i] = cnt[i] + 1;
      if (cnt[i] >= ((i == 0) ? FAST_HALF : SLOW_HALF)) begin
        cnt[i] = 0;
        tach[i] <= ~tach[i];
      end
    end
  end
endmodule // afc_fan_model
`default_nettype wire

// >>> testbench/afc_checker.sv
// Port-level checker for the fan control block.
`timescale 1ns/100ps
`default_nettype none
module afc_checker #(
  parameter SPINUP_CYC = 200,
  parameter DELAY_CYC  = 100
) (
  // Clock and reset.
  input wire        clk,
  input wire        reset,
  // Register bus.
  input wire [6:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  // Temperatures and fan side.
  input wire [7:0]  temp_local,
  input wire [7:0]  temp_remote_a,
  input wire [7:0]  temp_remote_b,
  input wire [7:0]  tach_or_logic_pin,
  input wire [7:0]  dac_code,
  input wire        pwm_out,
  input wire        int_n
);
  reg  [7:0] cfg_s;
  reg  [7:0] dac_s;
  reg  [7:0] pwm_s;
  reg  [7:0] test_s;
  reg  [7:0] tmin_s;
  wire [4:0] idx = avs_address[6:2];
  // Shadows of the controls, taken at the edge where a write completes.
  always @(posedge clk) begin
    if (reset) begin
      cfg_s  <= 8'h00;
      dac_s  <= 8'hff;
      pwm_s  <= 8'hff;
      test_s <= 8'h00;
      tmin_s <= 8'h7f;
    end else if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
      case (idx)
        5'h00: cfg_s <= avs_writedata[7:0];
        5'h04: dac_s <= avs_writedata[7:0];
        5'h05: pwm_s <= avs_writedata[7:0];
        5'h10: tmin_s <= avs_writedata[7:0];
        5'h14: test_s <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // No request waits more than one cycle.
  bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  rdata_upper_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && idx == 5'h07
    |-> avs_readdata[7:0] == 8'h00) else $error("unmapped read not zero");
  manual_dac_a: assert property ((!cfg_s[0] && $stable(dac_s)) [*3] |-> dac_code == dac_s)
    else $error("manual DAC code differs from register");
  pwm_polarity_a: assert property ((!cfg_s[0] && pwm_s == 8'h00 && $stable(test_s)) [*3]
    |-> pwm_out == test_s[1]) else $error("pulse output polarity wrong");
  int_gate_a: assert property ((!cfg_s[1]) [*3] |-> int_n)
    else $error("interrupt low while disabled");
  dac_gap_a: assert property ((cfg_s[0] && cfg_s[5]) [*3]
    |-> !(dac_code > 8'hf0 && dac_code < 8'hff)) else $error("DAC code between 240 and 255");
  dac_floor_a: assert property ((cfg_s[0] && cfg_s[5] && $stable(dac_s)) [*3]
    |-> dac_code == 8'h00 || dac_code >= {dac_s[7:4], 4'h0}) else $error("DAC below floor");
  spinup_full_a: assert property ($rose(cfg_s[0]) && cfg_s[5] &&
    $signed(temp_local) > $signed(tmin_s) |-> ##[1:4] (dac_code == 8'hff) [*8])
    else $error("no full drive at fan start");
endmodule // afc_checker
bind afc_fan_control afc_checker #(.SPINUP_CYC(SPINUP_CYC), .DELAY_CYC(DELAY_CYC)) i_afc_checker (
  .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .temp_local(temp_local),
  .temp_remote_a(temp_remote_a), .temp_remote_b(temp_remote_b),
  .tach_or_logic_pin(tach_or_logic_pin), .dac_code(dac_code), .pwm_out(pwm_out), .int_n(int_n));
`default_nettype wire

// >>> testbench/tb.sv
// Register-level testbench for the fan control block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin \
  checks_done = checks_done + 1; \
  if ((a) !== (b)) begin \
    n_fail = n_fail + 1; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); \
  end \
end
module tb;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [6:0]  avs_address = 7'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  temp_local = 8'h00;
  logic [7:0]  temp_remote_a = 8'h00;
  logic [7:0]  temp_remote_b = 8'h64;
  logic [7:0]  tach;
  logic [7:0]  dac_code;
  logic        pwm_out;
  logic        int_n;
  logic [7:0]  q;
  integer      n_fail = 0;
  integer      checks_done = 0;
  integer      j;
  logic [4:0]  ri [0:7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h18};
  logic [7:0]  rv [0:7] = '{8'h00, 8'h00, 8'h55, 8'h55, 8'hff, 8'hff, 8'h00, 8'hff};
  // Clock at 25 MHz.
  always #20 clk = ~clk;
  afc_fan_control #(.SPINUP_CYC(200), .DELAY_CYC(100)) i_afc_fan_control (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .temp_local(temp_local),
    .temp_remote_a(temp_remote_a), .temp_remote_b(temp_remote_b), .tach_or_logic_pin(tach),
    .dac_code(dac_code), .pwm_out(pwm_out), .int_n(int_n));
  afc_fan_model #(.FAST_HALF(1111), .SLOW_HALF(4444)) i_afc_fan_model (.clk(clk), .tach(tach));
  // One bus cycle; the request stands until waitrequest is seen low.
  task bus(input logic wr, input logic [4:0] idx, input logic [7:0] d, output logic [7:0] r);
    integer k;
    begin
      k = 0;
      @(posedge clk);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && k < 20) begin
        k = k + 1;
        @(posedge clk);
      end
      r = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      `CHK(k < 20, 1'b1)
    end
  endtask
  task wr(input logic [4:0] idx, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, idx, d, r);
  endtask
  // Temperatures change, then the control law gets time to settle.
  task temps(input logic [7:0] l, input logic [7:0] a);
    @(posedge clk);
    temp_local <= l;
    temp_remote_a <= a;
    repeat (10) @(posedge clk);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Watchdog against a hung bus or a stuck sequence.
  initial begin
    repeat (98000) @(posedge clk);
    n_fail = n_fail + 1;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    // Reset values, and an unmapped word that ignores writes.
    wr(5'h07, 8'h5a);
    for (j = 0; j < 8; j = j + 1) begin
      bus(1'b0, ri[j], 8'h00, q);
      `CHK(q, rv[j])
    end
    wr(5'h01, 8'h80);
    bus(1'b0, 5'h01, 8'h00, q);
    `CHK(q, 8'h80)
    wr(5'h01, 8'h00);
    // Start temperatures; remote b is parked at 127 degrees to leave it out.
    wr(5'h10, 8'h1e);
    wr(5'h11, 8'h14);
    wr(5'h12, 8'h7f);
    temps(8'h28, 8'h00);
    // Automatic bits set but monitoring off: drive stays manual.
    wr(5'h04, 8'h5a);
    wr(5'h05, 8'h00);
    wr(5'h00, 8'h60);
    repeat (5) @(posedge clk);
    `CHK(dac_code, 8'h5a)
    `CHK(pwm_out, 1'b0)
    wr(5'h14, 8'h02);
    repeat (5) @(posedge clk);
    `CHK(pwm_out, 1'b1)
    wr(5'h14, 8'h00);
    // Fan 0 divides by 1, fans 1 to 7 by 4; limits of fans 0 and 1 sit just above the expected count of 4.
    wr(5'h02, 8'ha8);
    wr(5'h03, 8'haa);
    wr(5'h18, 8'h06);
    wr(5'h19, 8'h06);
    wr(5'h06, 8'h03);
    wr(5'h00, 8'h63);
    repeat (20) @(posedge clk);
    `CHK(dac_code, 8'hff)
    `CHK(int_n, 1'b0)
    repeat (250) @(posedge clk);
    `CHK(dac_code, 8'ha0)
    bus(1'b0, 5'h06, 8'h00, q);
    `CHK(q[0], 1'b1)
    wr(5'h06, 8'h01);
    repeat (3) @(posedge clk);
    `CHK(int_n, 1'b1)
    temps(8'h32, 8'h00);
    `CHK(dac_code, 8'hf0)
    temps(8'h33, 8'h00);
    `CHK(dac_code, 8'hff)
    temps(8'h28, 8'h23);
    `CHK(dac_code, 8'hc8)
    temps(8'h1b, 8'h11);
    `CHK(dac_code != 8'h00, 1'b1)
    temps(8'h1a, 8'h10);
    `CHK(dac_code, 8'h00)
    `CHK(int_n, 1'b0)
    wr(5'h06, 8'h01);
    // Fans 0 and 1 measured by now; counts stay under their limits only with the divisors.
    repeat (48000) @(posedge clk);
    bus(1'b0, 5'h06, 8'h00, q);
    `CHK(q[1], 1'b0)
    // Fan 0 result: two tach periods of 4444 cycles give about four ticks.
    bus(1'b0, 5'h08, 8'h00, q);
    `CHK(q >= 8'h03 && q <= 8'h05, 1'b1)
    // Fan 2 is still in progress; a limit below its count must flag it.
    wr(5'h1a, 8'h02);
    repeat (42000) @(posedge clk);
    bus(1'b0, 5'h06, 8'h00, q);
    `CHK(q[1], 1'b1)
    `CHK(int_n, 1'b0)
    // Fan 2 result: divisor four over 17776 cycles also gives about four.
    bus(1'b0, 5'h0a, 8'h00, q);
    `CHK(q >= 8'h03 && q <= 8'h05, 1'b1)
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
